// ===== rtl/pci_defines.vh
// Constants shared by the printer command interpreter design files.
`ifndef PCI_DEFINES_VH
`define PCI_DEFINES_VH
`define PCI_CH_BS      7'h08
`define PCI_CH_HT      7'h09
`define PCI_CH_LF      7'h0A
`define PCI_CH_VT      7'h0B
`define PCI_CH_FF      7'h0C
`define PCI_CH_CR      7'h0D
`define PCI_CH_SO      7'h0E
`define PCI_CH_SI      7'h0F
`define PCI_CH_DC2     7'h12
`define PCI_CH_DC4     7'h14
`define PCI_CH_ESC     7'h1B
`define PCI_CH_SP      7'h20
`define PCI_CH_DEL     7'h7F
`define PCI_CH_ACK     8'h06
`define PCI_CH_NAK     8'h15
`define PCI_CH_3       7'h33
`define PCI_CH_4       7'h34
`define PCI_CH_0       7'h30
`define PCI_CH_1       7'h31
`define PCI_CH_9       7'h39
`define PCI_CH_UA      7'h41
`define PCI_CH_UF      7'h46
`define PCI_CH_UD      7'h44
`define PCI_CH_UM      7'h4D
`define PCI_CH_UP      7'h50
`define PCI_CH_US      7'h53
`define PCI_CH_UU      7'h55
`define PCI_SPOKE_OFS  7'h20
`define PCI_VSI_RESET  7'h08
`define PCI_LPP_SHORT  7'h42
`define PCI_LPP_LONG   7'h48
`define PCI_BOT_SHORT  12'h210
`define PCI_BOT_LONG   12'h240
`define PCI_RMARGIN    12'h624
`define PCI_GFX_HSTEP  7'h01
`define PCI_GFX_VSTEP  7'h01
`define PCI_TBL_LO     16'h0040
`define PCI_TBL_HI     16'h0107
`define PCI_TBL_BYTES  200
`define PCI_FIFO_DEPTH 16
`define PCI_FIFO_AW    4
`endif

// ===== rtl/pci_fifo.v
// Parameterised receive FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module pci_fifo #(
	parameter WIDTH = 7,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset.
	input  wire             core_clk_i,
	input  wire             rst_b_i,
	// Fill side.
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	// Drain side.
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	reg             room;
	wire [AW:0]     next_count;
	wire            do_wr;
	wire            do_rd;
	// Ready comes from a flop so the sender never sees a combinational path.
	assign in_ready_o  = room;
	assign out_valid_o = (count != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_ptr];
	assign do_wr       = in_valid_i & in_ready_o;
	assign do_rd       = out_valid_o & out_ready_i;
	assign next_count  = (do_wr && !do_rd) ? count + 1'b1
		: (do_rd && !do_wr) ? count - 1'b1 : count;
	always @(posedge core_clk_i) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
			room   <= 1'b1;
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= next_count;
			room  <= (next_count != DEPTH[AW:0]);
		end
	end
endmodule // pci_fifo
`default_nettype wire

// ===== rtl/pci_interp.v
// Printer command interpreter: decodes the host stream into motion and print events.
`timescale 1ns/1ps
`default_nettype none
`include "pci_defines.vh"
module pci_interp (
	// Clock and reset.
	input  wire        core_clk_i,
	input  wire        rst_b_i,
	// Received characters from the serial receiver.
	input  wire [6:0]  rx_char_i,
	input  wire        rx_valid_i,
	output wire        rx_ready_o,
	// Control panel and configuration.
	input  wire        panel_lf_i,
	input  wire        panel_ff_i,
	input  wire        page_long_i,
	input  wire        prop_mode_i,
	input  wire [6:0]  horizontal_step_index_i,
	input  wire [6:0]  offset_i,
	input  wire [6:0]  top_margin_line_i,
	// Paper motion command, signed 1/48 inch units.
	output reg         paper_move_o,
	output reg  [11:0] paper_amount_o,
	output reg         paper_reverse_o,
	// Carriage motion command.
	output reg         carr_move_o,
	output reg  [6:0]  carr_amount_o,
	output reg         carr_reverse_o,
	output reg         carr_return_o,
	// Print strike command.
	output reg         strike_o,
	output reg  [6:0]  strike_spoke_o,
	output reg  [2:0]  strike_energy_o,
	// Status and state.
	output reg         graphics_mode_o,
	output reg         program_mode_o,
	output reg         download_mode_o,
	output reg         auto_backward_o,
	output reg         table_downloaded_o,
	output reg  [6:0]  vertical_step_index_o,
	output reg  [6:0]  lines_per_page_o,
	output reg  [11:0] bottom_margin_o,
	output reg  [11:0] right_margin_o,
	output reg  [11:0] left_margin_o,
	output reg  [11:0] vert_pos_o,
	output reg         buffers_clear_o,
	// Reply to host.
	output reg         tx_valid_o,
	output reg  [7:0]  tx_char_o,
	// Downloaded table write port.
	output reg         tbl_we_o,
	output reg  [7:0]  tbl_addr_o,
	output reg  [7:0]  tbl_data_o
);
	localparam ST_IDLE  = 6'b000001;
	localparam ST_ESC   = 6'b000010;
	localparam ST_ESCSO = 6'b000100;
	localparam ST_ESCCR = 6'b001000;
	localparam ST_PROG2 = 6'b010000;
	localparam ST_DL    = 6'b100000;
	localparam RF_START = 3'd0;
	localparam RF_TYPE  = 3'd1;
	localparam RF_COUNT = 3'd2;
	localparam RF_ADDR  = 3'd3;
	localparam RF_DATA  = 3'd4;

	wire [6:0] ch;
	wire       ch_valid;
	reg  [5:0] state;
	reg  [2:0] rf;
	reg        nib_hi;
	reg  [3:0] hi_nib;
	reg  [7:0] cksum;
	reg  [7:0] remain;
	reg  [1:0] addr_cnt;
	reg [15:0] load_addr;
	reg        keep_rec;
	reg        addr_bad;
	reg  [6:0] spoke;
	reg  [3:0] hex_val;
	reg        hex_ok;
	wire [7:0] full_byte;
	wire [6:0] step;
	wire [7:0] next_sum;
	wire [14:0] ff_amount;
	wire [15:0] tbl_offset;

	// The character FIFO is drained every cycle (out_ready_i tied high), so it never holds more than one character.
	pci_fifo #(.WIDTH(7), .DEPTH(`PCI_FIFO_DEPTH), .AW(`PCI_FIFO_AW)) u_fifo (
		.core_clk_i  (core_clk_i),
		.rst_b_i     (rst_b_i),
		.in_data_i   (rx_char_i),
		.in_valid_i  (rx_valid_i),
		.in_ready_o  (rx_ready_o),
		.out_data_o  (ch),
		.out_valid_o (ch_valid),
		.out_ready_i (1'b1)
	);

	always @* begin
		hex_ok  = 1'b1;
		hex_val = 4'h0;
		if (ch >= `PCI_CH_0 && ch <= `PCI_CH_9) begin
			hex_val = ch[3:0];
		end else if (ch >= `PCI_CH_UA && ch <= `PCI_CH_UF) begin
			hex_val = ch[3:0] + 4'h9;
		end else begin
			hex_ok = 1'b0;
		end
	end
	assign full_byte = {hi_nib, hex_val};
	assign next_sum  = cksum + full_byte;
	// Graphics mode fixes the line step at one increment.
	assign step      = graphics_mode_o ? `PCI_GFX_VSTEP : vertical_step_index_o;
	// Form feed is a relative move; the product is cut to the amount's width on purpose.
	assign ff_amount = ({8'h00, lines_per_page_o} + {8'h00, top_margin_line_i})
		* {8'h00, vertical_step_index_o};
	assign tbl_offset = load_addr - `PCI_TBL_LO;

	always @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state                 <= ST_IDLE;
			rf                    <= RF_START;
			nib_hi                <= 1'b1;
			hi_nib                <= 4'h0;
			cksum                 <= 8'h00;
			remain                <= 8'h00;
			addr_cnt              <= 2'h0;
			load_addr             <= 16'h0000;
			keep_rec              <= 1'b0;
			addr_bad              <= 1'b0;
			spoke                 <= 7'h00;
			paper_move_o          <= 1'b0;
			paper_amount_o        <= 12'h000;
			paper_reverse_o       <= 1'b0;
			carr_move_o           <= 1'b0;
			carr_amount_o         <= 7'h00;
			carr_reverse_o        <= 1'b0;
			carr_return_o         <= 1'b0;
			strike_o              <= 1'b0;
			strike_spoke_o        <= 7'h00;
			strike_energy_o       <= 3'h0;
			graphics_mode_o       <= 1'b0;
			program_mode_o        <= 1'b0;
			download_mode_o       <= 1'b0;
			auto_backward_o       <= 1'b1;
			table_downloaded_o    <= 1'b0;
			vertical_step_index_o <= `PCI_VSI_RESET;
			lines_per_page_o      <= `PCI_LPP_SHORT;
			bottom_margin_o       <= `PCI_BOT_SHORT;
			right_margin_o        <= `PCI_RMARGIN;
			left_margin_o         <= 12'h000;
			vert_pos_o            <= 12'h000;
			buffers_clear_o       <= 1'b1;
			tx_valid_o            <= 1'b0;
			tx_char_o             <= 8'h00;
			tbl_we_o              <= 1'b0;
			tbl_addr_o            <= 8'h00;
			tbl_data_o            <= 8'h00;
		end else begin
			paper_move_o    <= 1'b0;
			carr_move_o     <= 1'b0;
			carr_return_o   <= 1'b0;
			strike_o        <= 1'b0;
			tx_valid_o      <= 1'b0;
			tbl_we_o        <= 1'b0;
			buffers_clear_o <= 1'b0;
			if (buffers_clear_o) begin
				// Page switch is sampled after reset release and again after the ESC CR P remote reset.
				lines_per_page_o <= page_long_i ? `PCI_LPP_LONG : `PCI_LPP_SHORT;
				bottom_margin_o  <= page_long_i ? `PCI_BOT_LONG : `PCI_BOT_SHORT;
			end
			if (panel_lf_i) begin
				paper_move_o    <= 1'b1;
				paper_amount_o  <= {5'h00, step};
				paper_reverse_o <= 1'b0;
			end else if (panel_ff_i) begin
				paper_move_o    <= 1'b1;
				paper_amount_o  <= ff_amount[11:0];
				paper_reverse_o <= 1'b0;
			end
			if (ch_valid) begin
				case (state)
				ST_IDLE: begin
					if (ch == `PCI_CH_ESC) begin
						state <= ST_ESC;
					end else if (ch == `PCI_CH_LF) begin
						paper_move_o    <= 1'b1;
						paper_amount_o  <= {5'h00, step};
						paper_reverse_o <= 1'b0;
					end else if (ch == `PCI_CH_FF) begin
						// Amount runs one page plus the top margin lines further down, at the unshortened step.
						paper_move_o    <= 1'b1;
						paper_amount_o  <= ff_amount[11:0];
						paper_reverse_o <= 1'b0;
					end else if (ch == `PCI_CH_CR) begin
						graphics_mode_o <= 1'b0;
						carr_return_o   <= 1'b1;
					end else if (ch == `PCI_CH_SI) begin
						program_mode_o <= 1'b0;
					end else if (ch == `PCI_CH_SP || ch == `PCI_CH_BS) begin
						carr_move_o    <= 1'b1;
						carr_amount_o  <= graphics_mode_o ? `PCI_GFX_HSTEP
							: horizontal_step_index_i;
						carr_reverse_o <= (ch == `PCI_CH_BS);
					end else if (program_mode_o && ch > `PCI_CH_SP && ch != `PCI_CH_DEL) begin
						spoke <= ch - `PCI_SPOKE_OFS;
						state <= ST_PROG2;
					end else if (ch > `PCI_CH_SP && ch != `PCI_CH_DEL) begin
						strike_o        <= 1'b1;
						strike_spoke_o  <= ch - `PCI_SPOKE_OFS;
						strike_energy_o <= 3'h0;
						carr_move_o     <= ~graphics_mode_o;
						carr_amount_o   <= horizontal_step_index_i;
						carr_reverse_o  <= 1'b0;
					end
				end
				ST_ESC: begin
					state <= ST_IDLE;
					if (ch == `PCI_CH_LF) begin
						paper_move_o    <= 1'b1;
						paper_amount_o  <= {5'h00, step};
						paper_reverse_o <= 1'b1;
					end else if (ch == `PCI_CH_UU || ch == `PCI_CH_UD) begin
						paper_move_o    <= 1'b1;
						paper_amount_o  <= {6'h00, vertical_step_index_o[6:1]};
						paper_reverse_o <= (ch == `PCI_CH_UD);
					end else if (ch == `PCI_CH_3) begin
						graphics_mode_o <= 1'b1;
					end else if (ch == `PCI_CH_4) begin
						graphics_mode_o <= 1'b0;
					end else if (ch == `PCI_CH_SO) begin
						state <= ST_ESCSO;
					end else if (ch == `PCI_CH_CR) begin
						state <= ST_ESCCR;
					end
				end
				ST_ESCSO: begin
					state <= ST_IDLE;
					if (ch == `PCI_CH_UM) begin
						program_mode_o <= 1'b1;
					end else if (ch == `PCI_CH_DC2) begin
						download_mode_o <= 1'b1;
						rf              <= RF_START;
						state           <= ST_DL;
					end
				end
				ST_ESCCR: begin
					state <= ST_IDLE;
					if (ch == `PCI_CH_UP) begin
						graphics_mode_o       <= 1'b0;
						auto_backward_o       <= 1'b1;
						carr_return_o         <= 1'b1;
						vert_pos_o            <= 12'h000;
						vertical_step_index_o <= `PCI_VSI_RESET;
						left_margin_o         <= 12'h000;
						right_margin_o        <= `PCI_RMARGIN;
						buffers_clear_o       <= 1'b1;
						table_downloaded_o    <= 1'b0;
					end
				end
				ST_PROG2: begin
					// Second character is never checked for a control code here.
					state           <= ST_IDLE;
					strike_o        <= (ch[6:4] != 3'h0);
					strike_spoke_o  <= spoke;
					strike_energy_o <= ch[6:4];
					carr_move_o     <= 1'b1;
					carr_amount_o   <= (prop_mode_i ? {3'h0, ch[3:0]}
						: horizontal_step_index_i) + offset_i;
					carr_reverse_o  <= 1'b0;
				end
				ST_DL: begin
					if (rf == RF_START) begin
						if (ch == `PCI_CH_DC4) begin
							download_mode_o <= 1'b0;
							state           <= ST_IDLE;
						end else if (ch == `PCI_CH_US) begin
							rf <= RF_TYPE;
						end
					end else if (!hex_ok || (rf == RF_TYPE && ch != `PCI_CH_0
						&& ch != `PCI_CH_1 && ch != `PCI_CH_9)) begin
						tx_valid_o         <= 1'b1;
						tx_char_o          <= `PCI_CH_NAK;
						download_mode_o    <= 1'b0;
						table_downloaded_o <= 1'b0;
						state              <= ST_IDLE;
					end else if (rf == RF_TYPE) begin
						keep_rec <= (ch == `PCI_CH_1);
						addr_bad <= 1'b0;
						rf       <= RF_COUNT;
						nib_hi   <= 1'b1;
						cksum    <= 8'h00;
						addr_cnt <= 2'h0;
					end else if (nib_hi) begin
						hi_nib <= hex_val;
						nib_hi <= 1'b0;
					end else begin
						nib_hi <= 1'b1;
						cksum  <= next_sum;
						if (rf == RF_COUNT) begin
							remain <= full_byte;
							rf     <= RF_ADDR;
						end else begin
							remain <= remain - 8'h01;
							if (rf == RF_ADDR) begin
								load_addr <= {load_addr[7:0], full_byte};
								addr_cnt  <= addr_cnt + 2'h1;
								if (addr_cnt == 2'h1) begin
									rf       <= RF_DATA;
									// Only the start is judged here; overruns are caught per byte.
									addr_bad <= ({load_addr[7:0], full_byte} < `PCI_TBL_LO)
										|| ({load_addr[7:0], full_byte} > `PCI_TBL_HI);
								end
							end
							if (remain == 8'h01) begin
								// Last byte is the checksum.
								rf     <= RF_START;
								// Header and end records pass without a reply unless corrupt.
								tx_valid_o <= keep_rec || (next_sum != 8'h00);
								if (next_sum != 8'h00 || (keep_rec && addr_bad)) begin
									tx_char_o          <= `PCI_CH_NAK;
									download_mode_o    <= 1'b0;
									table_downloaded_o <= 1'b0;
									state              <= ST_IDLE;
								end else begin
									tx_char_o <= `PCI_CH_ACK;
									if (keep_rec) begin
										table_downloaded_o <= 1'b1;
									end
								end
							end else if (rf == RF_DATA) begin
								load_addr <= load_addr + 16'h0001;
								if (load_addr > `PCI_TBL_HI) begin
									addr_bad <= 1'b1;
								end else if (keep_rec && !addr_bad) begin
									tbl_we_o   <= 1'b1;
									tbl_addr_o <= tbl_offset[7:0];
									tbl_data_o <= full_byte;
								end
							end
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule // pci_interp
`default_nettype wire

// ===== verification/pci_interp_checker.sv
// Concurrent assertions on the ports of the printer command interpreter.
`timescale 1ns/1ps
`default_nettype none
module pci_interp_checker (
	// Clock and reset.
	input wire logic        core_clk_i,
	input wire logic        rst_b_i,
	// Stream and switches.
	input wire logic [6:0]  rx_char_i,
	input wire logic        rx_valid_i,
	input wire logic        page_long_i,
	// Watched outputs.
	input wire logic        carr_move_o,
	input wire logic        strike_o,
	input wire logic [2:0]  strike_energy_o,
	input wire logic        graphics_mode_o,
	input wire logic        program_mode_o,
	input wire logic        download_mode_o,
	input wire logic        auto_backward_o,
	input wire logic [6:0]  vertical_step_index_o,
	input wire logic [6:0]  lines_per_page_o,
	input wire logic [11:0] bottom_margin_o,
	input wire logic [11:0] right_margin_o,
	input wire logic [11:0] left_margin_o,
	input wire logic [11:0] vert_pos_o,
	input wire logic        buffers_clear_o,
	input wire logic        tx_valid_o,
	input wire logic [7:0]  tx_char_o,
	input wire logic        tbl_we_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Characters take two edges to act, so causes are looked up two edges back.
	sequence rst_done;
		$rose(rst_b_i);
	endsequence
	sequence nak_sent;
		tx_valid_o && tx_char_o == 8'h15;
	endsequence
	reset_vals_a: assert property (rst_done |-> vertical_step_index_o == 7'h08 && vert_pos_o == 12'h000 && right_margin_o == 12'h624 && left_margin_o == 12'h000 && auto_backward_o && !graphics_mode_o) else $error("reset values wrong");
	page_size_a: assert property (rst_done |=> lines_per_page_o == ($past(page_long_i) ? 7'h48 : 7'h42) && bottom_margin_o == ($past(page_long_i) ? 12'h240 : 12'h210)) else $error("page size wrong");
	buf_clear_a: assert property (rst_done |-> buffers_clear_o ##1 !buffers_clear_o) else $error("buffer clear pulse wrong");
	gfx_enter_a: assert property ($rose(graphics_mode_o) |-> $past(rx_valid_i, 2) && $past(rx_char_i, 2) == 7'h33) else $error("graphics entered without cause");
	gfx_leave_a: assert property ($fell(graphics_mode_o) |-> $past(rx_char_i, 2) inside {7'h0D, 7'h34, 7'h50}) else $error("graphics left without cause");
	gfx_strike_a: assert property (graphics_mode_o && strike_o |-> !carr_move_o) else $error("graphics strike moved carriage");
	prog_enter_a: assert property ($rose(program_mode_o) |-> $past(rx_char_i, 2) == 7'h4D) else $error("program mode entered without cause");
	prog_leave_a: assert property ($fell(program_mode_o) |-> $past(rx_char_i, 2) == 7'h0F) else $error("program mode left without cause");
	nak_exit_a: assert property (nak_sent |-> ##[0:2] !download_mode_o) else $error("download kept after refusal");
	reply_code_a: assert property (tx_valid_o |-> tx_char_o == 8'h06 || tx_char_o == 8'h15) else $error("bad reply code");
	tbl_write_a: assert property (tbl_we_o |-> download_mode_o) else $error("table written outside download");
	normal_energy_a: assert property (strike_o && !program_mode_o |-> strike_energy_o == 3'h0) else $error("normal strike energy set");
endmodule // pci_interp_checker
bind pci_interp pci_interp_checker pci_interp_checker_inst (.*);
`default_nettype wire

// ===== verification/pci_host_model.sv
// Host model: sends characters to the printer and collects its replies.
`timescale 1ns/1ps
`default_nettype none
module pci_host_model (
	// Clock.
	input  wire logic       core_clk_i,
	// Character stream to the printer.
	output var  logic [6:0] rx_char_o,
	output var  logic       rx_valid_o,
	input  wire logic       rx_ready_i,
	// Replies from the printer.
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_char_i
);
	int         n_replies = 0;
	logic [7:0] last_reply = 8'h00;
	initial begin
		rx_char_o = 7'h00;
		rx_valid_o = 1'b0;
	end
	// Replies stand one cycle, so every edge is watched.
	always @(posedge core_clk_i) begin
		if (tx_valid_i) begin
			n_replies <= n_replies + 1;
			last_reply <= tx_char_i;
		end
	end
	// A character is held until the edge that samples ready high.
	task automatic send_char(input logic [6:0] c);
		int i;
		@(negedge core_clk_i);
		rx_char_o = c;
		rx_valid_o = 1'b1;
		i = 0;
		do begin
			@(posedge core_clk_i);
			i++;
		end while (!rx_ready_i && i < 100);
	endtask
	// A released line shows the inverse of its last value, never a stale copy.
	task automatic idle();
		@(negedge core_clk_i);
		rx_valid_o = 1'b0;
		rx_char_o = ~rx_char_o;
	endtask
	// Records go whole; the caller waits six cycles before the next one.
	task automatic send_str(input string s);
		for (int k = 0; k < s.len(); k++) begin
			send_char(7'(s[k]));
		end
		idle();
	endtask
endmodule // pci_host_model
`default_nettype wire

// ===== verification/pci_interp_tb.sv
// Self-checking testbench for the printer command interpreter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module pci_interp_tb;
	logic core_clk_i, rst_b_i, panel_lf_i, panel_ff_i, page_long_i, prop_mode_i;
	logic [6:0] horizontal_step_index_i, offset_i, top_margin_line_i;
	wire logic [6:0] rx_char_i, carr_amount_o, strike_spoke_o, vertical_step_index_o;
	wire logic [6:0] lines_per_page_o;
	wire logic rx_valid_i, rx_ready_o, paper_move_o, paper_reverse_o, carr_move_o;
	wire logic carr_reverse_o, carr_return_o, strike_o, graphics_mode_o, program_mode_o;
	wire logic download_mode_o, auto_backward_o, table_downloaded_o, buffers_clear_o;
	wire logic tx_valid_o, tbl_we_o;
	wire logic [11:0] paper_amount_o, bottom_margin_o, right_margin_o, left_margin_o, vert_pos_o;
	wire logic [2:0] strike_energy_o;
	wire logic [7:0] tx_char_o, tbl_addr_o, tbl_data_o;
	int n_errors = 0;
	int comparisons = 0;
	int n_pm, n_cm, n_st, n_we, cm_sum, nr, n_cr;
	logic [11:0] pm_amt;
	logic pm_rev, bc_seen, cm_rev;
	logic [7:0] ta;
	logic [6:0] st_spoke;
	logic [2:0] st_en;
	logic [15:0] we_log;
	string bad[4] = '{"S1050040ABCD44", "S1G", "S5", "S1050108ABCD7A"};
	pci_interp pci_interp_inst (.*);
	pci_host_model pci_host_model_inst (.core_clk_i(core_clk_i), .rx_char_o(rx_char_i),
		.rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o),
		.tx_char_i(tx_char_o));
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	// Pulses last one cycle, so they are tallied mid-cycle where they are settled.
	always @(negedge core_clk_i) begin
		if (paper_move_o) begin
			n_pm++;
			pm_amt = paper_amount_o;
			pm_rev = paper_reverse_o;
		end
		if (carr_move_o) begin
			n_cm++;
			cm_sum += carr_amount_o;
			cm_rev = carr_reverse_o;
		end
		if (carr_return_o) n_cr++;
		if (strike_o) begin
			n_st++;
			st_spoke = strike_spoke_o;
			st_en = strike_energy_o;
		end
		if (tbl_we_o) begin
			n_we++;
			we_log = {we_log[7:0], tbl_data_o};
			ta = tbl_addr_o;
		end
		if (buffers_clear_o) bc_seen = 1'b1;
	end
	task automatic go(input string s);
		{n_pm, n_cm, n_st, n_we, cm_sum, n_cr} = '0;
		bc_seen = 1'b0;
		nr = pci_host_model_inst.n_replies;
		pci_host_model_inst.send_str(s);
		repeat (6) @(posedge core_clk_i);
	endtask
	task automatic mv(input string s, input logic [11:0] amt, input logic rev);
		go(s);
		`CHK("moves", 1, n_pm)
		`CHK("amount", amt, pm_amt)
		`CHK("reverse", rev, pm_rev)
	endtask
	task automatic pnl(input logic ff, input logic [11:0] amt);
		n_pm = 0;
		@(negedge core_clk_i) {panel_ff_i, panel_lf_i} = {ff, ~ff};
		@(negedge core_clk_i) {panel_ff_i, panel_lf_i} = 2'b00;
		repeat (3) @(posedge core_clk_i);
		`CHK("panel moves", 1, n_pm)
		`CHK("panel amount", amt, pm_amt)
		`CHK("panel reverse", 1'b0, pm_rev)
	endtask
	task automatic summarize();
		if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		n_errors++;
		summarize();
	end
	initial begin
		{rst_b_i, panel_lf_i, panel_ff_i, page_long_i, prop_mode_i} = '0;
		horizontal_step_index_i = 7'h0C;
		offset_i = 7'h01;
		top_margin_line_i = 7'h02;
		repeat (6) @(posedge core_clk_i);
		@(negedge core_clk_i) rst_b_i = 1'b1;
		repeat (2) @(posedge core_clk_i);
		`CHK("lpp", 7'h42, lines_per_page_o)
		`CHK("right", 12'h624, right_margin_o)
		`CHK("step", 7'h08, vertical_step_index_o)
		`CHK("bottom", 12'h210, bottom_margin_o)
		`CHK("left", 12'h000, left_margin_o)
		`CHK("auto back", 1'b1, auto_backward_o)
		`CHK("vert", 12'h000, vert_pos_o)
		`CHK("ready", 1'b1, rx_ready_o)
		mv("\n", 12'h008, 1'b0);
		mv("\033\n", 12'h008, 1'b1);
		mv("\033U", 12'h004, 1'b0);
		mv("\033D", 12'h004, 1'b1);
		mv("\f", 12'h220, 1'b0);
		pnl(1'b0, 12'h008);
		pnl(1'b1, 12'h220);
		go("\0333");
		`CHK("gfx", 1'b1, graphics_mode_o)
		mv("\n", 12'h001, 1'b0);
		mv("\033U", 12'h004, 1'b0);
		mv("\f", 12'h220, 1'b0);
		go(" ");
		`CHK("gfx space", 1, cm_sum)
		go("\010");
		`CHK("gfx backspace", 1, cm_sum)
		`CHK("backspace dir", 1'b1, cm_rev)
		go("A");
		`CHK("gfx carriage", 0, n_cm)
		`CHK("gfx strike", 1, n_st)
		go("\015");
		`CHK("gfx off", 1'b0, graphics_mode_o)
		`CHK("cr return", 1, n_cr)
		go("\0333\0334");
		`CHK("gfx esc4", 1'b0, graphics_mode_o)
		go("\033\016M");
		`CHK("prog", 1'b1, program_mode_o)
		go("E\035");
		`CHK("spoke", 7'h25, st_spoke)
		`CHK("energy", 3'h1, st_en)
		`CHK("spacing", 13, cm_sum)
		@(negedge core_clk_i) prop_mode_i = 1'b1;
		go("E:");
		`CHK("energy", 3'h3, st_en)
		`CHK("prop spacing", 11, cm_sum)
		mv("\n", 12'h008, 1'b0);
		go("\017");
		`CHK("prog off", 1'b0, program_mode_o)
		go("\033\016\022");
		`CHK("dl", 1'b1, download_mode_o)
		go("\015\nS1050040ABCD43");
		`CHK("ack", 8'h06, pci_host_model_inst.last_reply)
		`CHK("writes", 2, n_we)
		`CHK("data", 16'hABCD, we_log)
		`CHK("last addr", 8'h01, ta)
		go("S0030000FD");
		`CHK("ignored", nr, pci_host_model_inst.n_replies)
		`CHK("ignored writes", 0, n_we)
		go("\024");
		`CHK("dl off", 1'b0, download_mode_o)
		`CHK("table", 1'b1, table_downloaded_o)
		for (int i = 0; i < 4; i++) begin
			go("\033\016\022");
			go(bad[i]);
			`CHK("nak", 8'h15, pci_host_model_inst.last_reply)
			`CHK("nak count", nr + 1, pci_host_model_inst.n_replies)
			if (i == 3) `CHK("bad addr writes", 0, n_we)
			`CHK("dl abort", 1'b0, download_mode_o)
			`CHK("resident", 1'b0, table_downloaded_o)
		end
		go("\033\016\022S1050040ABCD43");
		`CHK("reload", 1'b1, table_downloaded_o)
		go("\024\0333\033\015P");
		`CHK("remote gfx", 1'b0, graphics_mode_o)
		`CHK("remote table", 1'b0, table_downloaded_o)
		`CHK("remote clear", 1'b1, bc_seen)
		`CHK("remote return", 1, n_cr)
		@(negedge core_clk_i) rst_b_i = 1'b0;
		page_long_i = 1'b1;
		repeat (2) @(negedge core_clk_i);
		rst_b_i = 1'b1;
		repeat (3) @(posedge core_clk_i);
		`CHK("lpp long", 7'h48, lines_per_page_o)
		`CHK("bottom long", 12'h240, bottom_margin_o)
		summarize();
	end
endmodule // pci_interp_tb
`default_nettype wire
